// ===== rtl/trim_regs_pkg.sv
// Purpose: Shared constants for the gain trim and equaliser configuration bank
// Assumes: Byte addresses are four times the printed register index
// Notes: Trim and config field layouts and the config reset value live here
package trim_regs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TRIM_W = 5;
  localparam int COEF_W = 12;
  localparam int NUM_TRIM = 6;
  // Printed register indices
  localparam logic [11:0] IDX_FG_B0_DUAL = 12'h352;
  localparam logic [11:0] IDX_FG_B1_DUAL = 12'h353;
  localparam logic [11:0] IDX_FG_A0_SINGLE = 12'h354;
  localparam logic [11:0] IDX_FG_A1_SINGLE = 12'h355;
  localparam logic [11:0] IDX_FG_B0_SINGLE = 12'h356;
  localparam logic [11:0] IDX_FG_B1_SINGLE = 12'h357;
  localparam logic [11:0] IDX_EQ_CONFIG = 12'h400;
  // Own choice: live status word
  localparam logic [11:0] IDX_STATUS = 12'h401;
  localparam logic [11:0] IDX_COEF_CHECK = 12'h402;
  localparam int TRIM_LSB = 0;
  localparam int TRIM_MSB = 4;
  localparam int SHARE_BIT = 6;
  localparam int MERGE_BIT = 5;
  localparam int SCW_LSB = 2;
  localparam int SCW_MSB = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h7f;
  localparam logic [7:0] TRIM_WMASK = 8'h1f;
  localparam logic [2:0] SCW_MAX = 3'h6;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h2;
  localparam logic [4:0] WEIGHT_BASE = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int FUSE_WAIT = 4;
endpackage : trim_regs_pkg

// ===== rtl/fuse_loader.sv
// Purpose: Copies fuse-stored trim values once after reset
// Assumes: Fuse word is stable; it arrives from outside so it is synchronised
// Notes: load_pulse is one cycle; done stays high until the next reset
`timescale 1ns/100ps
module fuse_loader #(
  parameter int WIDTH = 30
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] fuse_word,
  output logic [WIDTH-1:0] fuse_value,
  output logic load_pulse,
  output logic done
);
  import trim_regs_pkg::*;
  logic [WIDTH-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [2:0] cnt_reg, cnt_next;
  logic done_reg, done_next, pulse_reg, pulse_next;

  always_comb begin
    sync1_next = fuse_word;
    sync2_next = sync1_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    pulse_next = 1'b0;
    // Wait so the synchroniser holds settled fuse data before the copy
    if (!done_reg) begin
      if (cnt_reg == 3'(FUSE_WAIT)) begin
        done_next = 1'b1;
        pulse_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 3'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      cnt_reg <= 3'd0;
      done_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      pulse_reg <= pulse_next;
    end
  end

  assign fuse_value = sync2_reg;
  assign load_pulse = pulse_reg;
  assign done = done_reg;
endmodule : fuse_loader

// ===== rtl/coef_store.sv
// Purpose: Small equaliser coefficient memory with registered read
// Assumes: One write port, one read port, same clock
// Notes: Holds signed two's-complement taps
`timescale 1ns/100ps
module coef_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_reg;

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_reg <= mem[rd_addr];
  end

  assign rd_data = rd_reg;
endmodule : coef_store

// ===== rtl/gain_trim_and_fir_config_regs.sv
// Purpose: Fine-gain trim bank and programmable equaliser configuration over AXI4-Lite
// Assumes: core_clk 100 MHz, synchronous active-high reset
// Notes: Trims take fuse values shortly after reset; see coefficient port for taps
//
// Behaviour
// - Dual B bank0 trim, bits 4:0
// - Dual B bank1 trim, low five bits
// - Single-channel A bank0 trim register
// - Single-channel A bank1 trim register
// - Single-channel B bank0 trim register
// - Single-channel B bank1 trim register
// - Trims load factory fuse values
// - Share bit: channel B uses A coefficients
// - Merge bit joins both filters
// - Side weight 2^(field-16), values 0..6
// - Mode 0 disables, 2 enables equaliser
// - Coefficients are 12-bit signed values
`timescale 1ns/100ps
module gain_trim_and_fir_config_regs #(
  parameter int COEF_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [trim_regs_pkg::ADDR_W+1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [trim_regs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [trim_regs_pkg::ADDR_W+1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [trim_regs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [trim_regs_pkg::NUM_TRIM*trim_regs_pkg::TRIM_W-1:0] fuse_trim,
  input wire logic serial_link_enable,
  input wire logic coef_wr_en,
  input wire logic [$clog2(COEF_DEPTH)-1:0] coef_wr_addr,
  input wire logic [trim_regs_pkg::COEF_W-1:0] coef_wr_data,
  output logic [trim_regs_pkg::NUM_TRIM*trim_regs_pkg::TRIM_W-1:0] trim_out,
  output logic coef_share_bit,
  output logic filter_merge_bit,
  output logic [2:0] side_coef_weight,
  output logic [4:0] side_weight_exp_neg,
  output logic equaliser_enable,
  output logic [$clog2(COEF_DEPTH)-1:0] chan_b_coef_bank
);
  import trim_regs_pkg::*;

  // Refused at elaboration: one bank index bit at least, and a small store
  if (COEF_DEPTH < 2 || COEF_DEPTH > 256) begin : g_bad_depth
    $error("COEF_DEPTH out of range");
  end

  localparam int TOT_TRIM = NUM_TRIM * TRIM_W;
  localparam int CA_W = $clog2(COEF_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Fuse load and coefficient check port

  logic [TOT_TRIM-1:0] fuse_value;
  logic fuse_load;
  logic fuse_done;
  logic [COEF_W-1:0] coef_rd_data;
  logic [CA_W-1:0] coef_rd_addr_reg, coef_rd_addr_next;

  fuse_loader #(.WIDTH(TOT_TRIM)) u_fuse (
    .core_clk(core_clk),
    .reset(reset),
    .fuse_word(fuse_trim),
    .fuse_value(fuse_value),
    .load_pulse(fuse_load),
    .done(fuse_done)
  );

  coef_store #(.DEPTH(COEF_DEPTH), .WIDTH(COEF_W)) u_coef (
    .core_clk(core_clk),
    .wr_en(coef_wr_en),
    .wr_addr(coef_wr_addr),
    .wr_data(coef_wr_data),
    .rd_addr(coef_rd_addr_reg),
    .rd_data(coef_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus state

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_RESP = 3'b010,
    W_HOLD = 3'b100
  } wr_state_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_LOOK = 3'b010,
    R_RESP = 3'b100
  } rd_state_t;

  wr_state_t wst_reg, wst_next;
  rd_state_t rst_reg, rst_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W+1:0] awaddr_reg, awaddr_next, araddr_reg, araddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [TRIM_W-1:0] trim_reg [NUM_TRIM];
  logic [TRIM_W-1:0] trim_next [NUM_TRIM];
  logic [7:0] cfg_reg, cfg_next;
  logic [TOT_TRIM-1:0] trim_out_reg, trim_out_next;
  logic share_reg, share_next, merge_reg, merge_next, en_reg, en_next;
  logic [2:0] scw_reg, scw_next;
  logic [4:0] exp_reg, exp_next;
  logic [CA_W-1:0] bank_reg, bank_next;
  logic awready_reg, awready_next, wready_reg, wready_next;

  function automatic logic [11:0] word_index(input logic [ADDR_W+1:0] a);
    word_index = a[ADDR_W+1:2];
  endfunction : word_index

  function automatic int trim_slot(input logic [11:0] idx);
    if (idx == IDX_FG_B0_DUAL) trim_slot = 0;
    else if (idx == IDX_FG_B1_DUAL) trim_slot = 1;
    else if (idx == IDX_FG_A0_SINGLE) trim_slot = 2;
    else if (idx == IDX_FG_A1_SINGLE) trim_slot = 3;
    else if (idx == IDX_FG_B0_SINGLE) trim_slot = 4;
    else if (idx == IDX_FG_B1_SINGLE) trim_slot = 5;
    else trim_slot = -1;
  endfunction : trim_slot

  ////////////////////////////////////////////////////////////////////////////
  // Write channel and register updates

  always_comb begin
    logic [11:0] widx;
    int slot;
    logic do_write;
    widx = word_index(awaddr_reg);
    slot = trim_slot(widx);
    do_write = 1'b0;
    wst_next = wst_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    cfg_next = cfg_reg;
    for (int i = 0; i < NUM_TRIM; i++) begin
      trim_next[i] = trim_reg[i];
    end
    if (fuse_load) begin
      for (int i = 0; i < NUM_TRIM; i++) begin
        trim_next[i] = fuse_value[i*TRIM_W +: TRIM_W];
      end
    end
    case (wst_reg)
      W_IDLE: begin
        if (s_axi_awvalid && !aw_have_reg) begin
          aw_have_next = 1'b1;
          awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_reg) begin
          w_have_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
        end
        if (aw_have_reg && w_have_reg) begin
          wst_next = W_HOLD;
        end
      end
      W_HOLD: begin
        // Writes wait for the fuse copy so software values are not overwritten
        if (fuse_done && !fuse_load) begin
          do_write = 1'b1;
          wst_next = W_RESP;
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          wst_next = W_IDLE;
        end
      end
      default: wst_next = W_IDLE;
    endcase
    // Readies are registered so every bus output comes from a flop
    awready_next = (wst_next == W_IDLE) && !aw_have_next;
    wready_next = (wst_next == W_IDLE) && !w_have_next;
    if (do_write) begin
      bresp_next = RESP_OKAY;
      if (awaddr_reg[1:0] != 2'b00) begin
        bresp_next = RESP_SLVERR;
      end else if (slot >= 0) begin
        if (wstrb_reg[0]) begin
          trim_next[slot] = wdata_reg[TRIM_MSB:TRIM_LSB];
        end
      end else if (widx == IDX_EQ_CONFIG) begin
        if (wstrb_reg[0]) begin
          cfg_next = wdata_reg[7:0] & CFG_WMASK;
        end
      end else if (widx == IDX_STATUS || widx == IDX_COEF_CHECK) begin
        bresp_next = RESP_OKAY;
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  always_comb begin
    logic [11:0] ridx;
    int slot;
    ridx = word_index(araddr_reg);
    slot = trim_slot(ridx);
    rst_next = rst_reg;
    araddr_next = araddr_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    coef_rd_addr_next = coef_rd_addr_reg;
    case (rst_reg)
      R_IDLE: begin
        if (s_axi_arvalid) begin
          araddr_next = s_axi_araddr;
          rst_next = R_LOOK;
        end
      end
      R_LOOK: begin
        rresp_next = RESP_OKAY;
        rdata_next = '0;
        if (araddr_reg[1:0] != 2'b00) begin
          rresp_next = RESP_SLVERR;
        end else if (slot >= 0) begin
          rdata_next[TRIM_MSB:TRIM_LSB] = trim_reg[slot];
        end else if (ridx == IDX_EQ_CONFIG) begin
          rdata_next[7:0] = cfg_reg;
        end else if (ridx == IDX_STATUS) begin
          rdata_next[0] = fuse_done;
          rdata_next[1] = en_reg;
          rdata_next[2] = serial_link_enable;
        end else if (ridx == IDX_COEF_CHECK) begin
          // Coefficient read address advances by one after each check read
          rdata_next[COEF_W-1:0] = coef_rd_data;
          coef_rd_addr_next = coef_rd_addr_reg + CA_W'(1);
        end else begin
          rresp_next = RESP_SLVERR;
        end
        rst_next = R_RESP;
      end
      R_RESP: begin
        if (s_axi_rready) begin
          rst_next = R_IDLE;
        end
      end
      default: rst_next = R_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded equaliser controls

  always_comb begin
    share_next = cfg_reg[SHARE_BIT];
    merge_next = cfg_reg[MERGE_BIT];
    // Out-of-range weight is clamped to the largest legal step
    scw_next = (cfg_reg[SCW_MSB:SCW_LSB] > SCW_MAX) ? SCW_MAX : cfg_reg[SCW_MSB:SCW_LSB];
    exp_next = WEIGHT_BASE - {2'b00, scw_next};
    // Reserved mode codes leave the filter off
    en_next = (cfg_reg[MODE_MSB:MODE_LSB] == MODE_ON);
    // Bank 0 holds A taps; shared mode points B at it too
    bank_next = share_next ? CA_W'(0) : CA_W'(1);
    trim_out_next = '0;
    for (int i = 0; i < NUM_TRIM; i++) begin
      trim_out_next[i*TRIM_W +: TRIM_W] = trim_reg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wst_reg <= W_IDLE;
      rst_reg <= R_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      araddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
      rdata_reg <= '0;
      bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY;
      for (int i = 0; i < NUM_TRIM; i++) begin
        trim_reg[i] <= '0;
      end
      cfg_reg <= CFG_RESET;
      coef_rd_addr_reg <= '0;
      trim_out_reg <= '0;
      share_reg <= 1'b0;
      merge_reg <= 1'b0;
      scw_reg <= 3'h0;
      exp_reg <= WEIGHT_BASE;
      en_reg <= 1'b0;
      bank_reg <= CA_W'(1);
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else begin
      wst_reg <= wst_next;
      rst_reg <= rst_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      araddr_reg <= araddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      rdata_reg <= rdata_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      for (int i = 0; i < NUM_TRIM; i++) begin
        trim_reg[i] <= trim_next[i];
      end
      cfg_reg <= cfg_next;
      coef_rd_addr_reg <= coef_rd_addr_next;
      trim_out_reg <= trim_out_next;
      share_reg <= share_next;
      merge_reg <= merge_next;
      scw_reg <= scw_next;
      exp_reg <= exp_next;
      en_reg <= en_next;
      bank_reg <= bank_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  // Valids and read ready are single bits of the one-hot state flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = wst_reg[1];
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = rst_reg[0];
  assign s_axi_rvalid = rst_reg[2];
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign trim_out = trim_out_reg;
  assign coef_share_bit = share_reg;
  assign filter_merge_bit = merge_reg;
  assign side_coef_weight = scw_reg;
  assign side_weight_exp_neg = exp_reg;
  assign equaliser_enable = en_reg;
  assign chan_b_coef_bank = bank_reg;
endmodule : gain_trim_and_fir_config_regs

// ===== bench/gain_trim_and_fir_config_regs_asserts.sv
// Purpose: Port-level checks of the trim and equaliser bank
// Assumes: One clock, synchronous active-high reset
// Notes: AXI answer holds and config output relations
`timescale 1ns/100ps
module trim_bank_checker #(
  parameter int COEF_DEPTH = 16
) (
  input logic core_clk,
  input logic reset,
  input logic s_axi_awready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic coef_share_bit,
  input logic [2:0] side_coef_weight,
  input logic [4:0] side_weight_exp_neg,
  input logic [$clog2(COEF_DEPTH)-1:0] chan_b_coef_bank
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_answer;
    s_axi_rvalid;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_rd_answer_two: assert property (s_rd_taken |-> ##2 s_rd_answer)
    else $error("read answer not two cycles after address");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while response pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_weight_clamp: assert property (side_coef_weight <= 3'h6)
    else $error("side weight above six");
  a_weight_exp: assert property (side_weight_exp_neg == 5'h10 - {2'b00, side_coef_weight})
    else $error("weight exponent does not match side weight");
  a_share_bank: assert property (chan_b_coef_bank == (coef_share_bit ? 0 : 1))
    else $error("channel b coefficient bank does not follow share bit");
endmodule : trim_bank_checker

bind gain_trim_and_fir_config_regs trim_bank_checker #(.COEF_DEPTH(COEF_DEPTH)) u_chk (
  .core_clk(core_clk), .reset(reset), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .coef_share_bit(coef_share_bit),
  .side_coef_weight(side_coef_weight), .side_weight_exp_neg(side_weight_exp_neg),
  .chan_b_coef_bank(chan_b_coef_bank));

// ===== bench/gain_trim_and_fir_config_regs_tb.sv
// Purpose: Register-level test of the trim and equaliser bank
// Assumes: Answers sampled at the falling edge, taken at the next rising edge
// Notes: Coefficient check pointer is taken to start at tap 0 after reset
`timescale 1ns/100ps
module gain_trim_and_fir_config_regs_tb;
  import trim_regs_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0, coef_wr_addr = '0, chan_b_coef_bank;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, serial_link_enable = 0, coef_wr_en = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [29:0] fuse_trim = 30'h1ab5_c963, trim_out;
  logic [11:0] coef_wr_data = '0;
  logic coef_share_bit, filter_merge_bit, equaliser_enable;
  logic [2:0] side_coef_weight, w;
  logic [4:0] side_weight_exp_neg, v;
  logic [7:0] c;
  int n_fail = 0, n_tests = 0;
  gain_trim_and_fir_config_regs u_gain_trim_and_fir_config_regs (.*);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Address and data offered together; each released once taken
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] st);
    int i;
    logic ta, tw, tb;
    @(posedge core_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 100; i++) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) begin
        s_axi_bready <= 0;
        break;
      end
    end
    if (i == 100) begin
      n_fail++;
      close_out();
    end
  endtask : wr
  task automatic rdr(input logic [11:0] idx);
    int i;
    logic ta, tr;
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 100; i++) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 0;
      if (tr) begin
        s_axi_rready <= 0;
        break;
      end
    end
    if (i == 100) begin
      n_fail++;
      close_out();
    end
  endtask : rdr
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    @(posedge core_clk);
    @(negedge core_clk);
    check("reset_exp", side_weight_exp_neg, 5'h10);
    check("reset_en", equaliser_enable, 1'b0);
    check("reset_trim", trim_out, 32'h0000_0000);
    @(posedge core_clk);
    reset <= 0;
    for (int i = 0; i < 20; i++) begin
      rdr(IDX_STATUS);
      if (rd[0] === 1'b1) break;
    end
    check("fuse_done", rd[0], 1'b1);
    for (int i = 0; i < 6; i++) begin
      rdr(IDX_FG_B0_DUAL + 12'(i));
      check("trim_fuse", rd, {27'h0, fuse_trim[5*i+:5]});
      check("trim_rd_resp", rsp, RESP_OKAY);
      check("trim_out_fuse", trim_out[5*i+:5], fuse_trim[5*i+:5]);
    end
    rdr(IDX_EQ_CONFIG);
    check("cfg_reset", rd, {24'h0, CFG_RESET});
    // Reserved bits written as ones must read back zero
    for (int i = 0; i < 6; i++) begin
      v = 5'(7 * i + 3);
      wr(IDX_FG_B0_DUAL + 12'(i), {27'h7ff_ffff, v}, 4'hf);
      check("trim_wr_resp", rsp, RESP_OKAY);
      wr(IDX_FG_B0_DUAL + 12'(i), 32'h0000_0000, 4'he);
      rdr(IDX_FG_B0_DUAL + 12'(i));
      check("trim_rd", rd, {27'h0, v});
      check("trim_out", trim_out[5*i+:5], v);
    end
    // Every mode code and weight value, share and merge toggled
    for (int k = 0; k < 32; k++) begin
      c = {1'b1, k[0], ~k[0], 3'(k >> 2), 2'(k)};
      w = (c[4:2] > 3'h6) ? 3'h6 : c[4:2];
      wr(IDX_EQ_CONFIG, {24'hff_ffff, c}, 4'hf);
      rdr(IDX_EQ_CONFIG);
      check("cfg_rd", rd, {24'h0, c & CFG_WMASK});
      check("share", coef_share_bit, c[6]);
      check("bank", chan_b_coef_bank, c[6] ? 4'h0 : 4'h1);
      check("merge", filter_merge_bit, c[5]);
      check("weight", side_coef_weight, w);
      check("exp", side_weight_exp_neg, 5'h10 - {2'b00, w});
      check("enable", equaliser_enable, c[1:0] == MODE_ON);
    end
    wr(12'h351, 32'h0000_001f, 4'hf);
    check("unmapped_wr", rsp, RESP_SLVERR);
    rdr(12'h351);
    check("unmapped_rresp", rsp, RESP_SLVERR);
    check("unmapped_rd", rd, 32'h0000_0000);
    // Load taps before enabling: most negative and most positive
    @(posedge core_clk);
    coef_wr_en <= 1;
    coef_wr_data <= 12'h800;
    @(posedge core_clk);
    coef_wr_addr <= 4'h1;
    coef_wr_data <= 12'h7ff;
    @(posedge core_clk);
    coef_wr_en <= 0;
    rdr(IDX_COEF_CHECK);
    check("tap0", rd[11:0], 12'h800);
    rdr(IDX_COEF_CHECK);
    check("tap1", rd[11:0], 12'h7ff);
    wr(IDX_EQ_CONFIG, 32'h0000_0022, 4'hf);
    serial_link_enable <= 1;
    rdr(IDX_STATUS);
    check("status", rd[2:0], 3'h7);
    @(posedge core_clk);
    reset <= 1;
    repeat (2) @(posedge core_clk);
    reset <= 0;
    rdr(IDX_EQ_CONFIG);
    check("cfg_rereset", rd, {24'h0, CFG_RESET});
    close_out();
  end
endmodule : gain_trim_and_fir_config_regs_tb
